// ===== gcf_counter.sv
// Summary of operation
// - Nothing runs until software arms counter.
// - Simple mode counts source pulses; readable live.
// - Gated mode counts only while gate active.
// - Noncumulative: gate edge saves, reloads initial value.
// - Noncumulative: interrupt after every counting interval.
// - Cumulative: gate edge saves, counting never pauses.
// - Cumulative: interrupt after every active gate edge.
// - Position: direction high increments, low decrements.
// - Position count wraps at terminal count.
// - Direction input picks increment or decrement.
// - Live count readable; each save raises interrupt.
// - Measurement start, end edges each selectable, except buffered semiperiod (either edge).
// - Single period: count between active edges, save.
// - Single pulsewidth: count while active, save.
// - Buffered period: save, interrupt every period.
// - Buffered semiperiod: save, interrupt every half-period.
// - Buffered pulsewidth: save, interrupt every pulse.
// - Pulse generation: one pulse timed in source periods.
// - Gate triggers pulse: first edge or every.
// - Alternate output: two terminal-count pulses instead.
// - Counter is 24-bit up/down with load, save.
// - Source rising edges step the counter.
module gcf_counter
	import gcf_pkg::*;
(
	// Clock and reset
	input  wire logic        ref_clk,
	input  wire logic        rst_b,
	// External timing signals
	input  wire logic        src,
	input  wire logic        gate,
	input  wire logic        up_down,
	output logic             ctr_out,
	// Control
	input  wire logic        arm,
	input  wire logic        disarm,
	input  wire logic [3:0]  mode,
	input  wire logic [1:0]  start_sel,
	input  wire logic [1:0]  end_sel,
	input  wire logic [1:0]  trig_sel,
	input  wire logic        gate_invert,
	input  wire logic        alt_out,
	// Load registers
	input  wire logic [23:0] load_value,
	input  wire logic        load_init_wr,
	input  wire logic        load_width_wr,
	input  wire logic        count_wr,
	// Readback and events
	output logic [23:0]      count_value,
	output logic [23:0]      save_value,
	output logic             armed,
	output logic             terminal_count,
	output logic             save_irq,
	input  wire logic        save_ack
);

	gcf_top_state_t r;
	gcf_top_state_t n;
	gcf_mode_t      md;
	gcf_trig_t      trig;
	logic [23:0]    cnt_adv;
	logic [23:0]    cnt_down;
	logic           start_hit;
	logic           end_hit;
	logic           fire;
	logic           buffered;

	gcf_evt_if  s_evt ();
	gcf_evt_if  g_evt ();
	gcf_save_if sv ();

	////////////////////////////////////////////////////////////////////////
	// Input edges and save register
	gcf_edge u_src_edge (
		.ref_clk (ref_clk),
		.rst_b   (rst_b),
		.level   (src),
		.invert  (1'h0),
		.evt     (s_evt)
	);

	gcf_edge u_gate_edge (
		.ref_clk (ref_clk),
		.rst_b   (rst_b),
		.level   (gate),
		.invert  (gate_invert),
		.evt     (g_evt)
	);

	gcf_save u_save (
		.ref_clk (ref_clk),
		.rst_b   (rst_b),
		.sv      (sv)
	);

	assign md     = gcf_mode_t'(mode);
	assign trig   = gcf_trig_t'(trig_sel);
	assign sv.ack = save_ack;

	assign count_value    = r.count;
	assign save_value     = sv.held;
	assign save_irq       = sv.irq;
	assign ctr_out        = r.out;
	assign terminal_count = r.tc;
	assign armed          = (r.st != GCF_S_IDLE) && (r.st != GCF_S_DONE);

	////////////////////////////////////////////////////////////////////////
	// Step value, interval edges
	always_comb begin
		cnt_adv = r.count;
		if (s_evt.rise) begin
			cnt_adv = up_down ? r.count + GCF_CNT_ONE : r.count - GCF_CNT_ONE;
		end
	end

	assign cnt_down = r.count - GCF_CNT_ONE;
	assign fire     = s_evt.rise && (cnt_down == GCF_CNT_ZERO);
	assign buffered = (md == GCF_M_BPERIOD) || (md == GCF_M_BSEMI) || (md == GCF_M_BPWIDTH);

	always_comb begin
		if (md == GCF_M_BSEMI) begin
			start_hit = g_evt.rise | g_evt.fall;
			end_hit   = g_evt.rise | g_evt.fall;
		end else begin
			start_hit = gcf_edge_hit(start_sel, g_evt.rise, g_evt.fall);
			end_hit   = gcf_edge_hit(end_sel, g_evt.rise, g_evt.fall);
		end
	end

	////////////////////////////////////////////////////////////////////////
	// Function sequencer
	always_comb begin
		n        = r;
		n.tc     = 1'h0;
		sv.latch = 1'h0;
		sv.value = cnt_adv;
		if (alt_out) begin
			n.out = GCF_OUT_IDLE;
		end
		if (load_init_wr) begin
			n.load_init = load_value;
		end
		if (load_width_wr) begin
			n.load_width = load_value;
		end
		case (r.st)
			GCF_S_IDLE: begin
				if (arm) begin
					case (md)
						GCF_M_PULSE: begin
							n.count = r.load_init;
							n.out   = GCF_OUT_IDLE;
							n.st    = (trig == GCF_T_NONE) ? GCF_S_RUN : GCF_S_WAIT;
						end
						GCF_M_PERIOD, GCF_M_PWIDTH, GCF_M_BPERIOD, GCF_M_BSEMI,
						GCF_M_BPWIDTH: begin
							n.st = GCF_S_WAIT;
						end
						default: begin
							n.st = GCF_S_RUN;
						end
					endcase
				end
			end
			GCF_S_WAIT: begin
				if (md == GCF_M_PULSE) begin
					if (g_evt.rise) begin
						n.count = r.load_init;
						n.st    = GCF_S_RUN;
					end
				end else if (start_hit) begin
					n.count = r.load_init;
					n.st    = GCF_S_RUN;
				end
			end
			GCF_S_RUN: begin
				case (md)
					GCF_M_SIMPLE, GCF_M_POSITION: begin
						n.count = cnt_adv;
						n.tc    = s_evt.rise && (cnt_adv == GCF_CNT_ZERO);
					end
					GCF_M_GATED: begin
						if (g_evt.lvl) begin
							n.count = cnt_adv;
							n.tc    = s_evt.rise && (cnt_adv == GCF_CNT_ZERO);
						end
					end
					GCF_M_NONCUM: begin
						n.count = cnt_adv;
						if (g_evt.rise) begin
							sv.latch = 1'h1;
							n.count  = r.load_init;
						end
					end
					GCF_M_CUM: begin
						n.count  = cnt_adv;
						sv.latch = g_evt.rise;
					end
					GCF_M_PERIOD, GCF_M_PWIDTH: begin
						n.count = cnt_adv;
						if (end_hit) begin
							sv.latch = 1'h1;
							n.st     = GCF_S_DONE;
						end
					end
					GCF_M_PULSE: begin
						if (trig == GCF_T_EVERY && g_evt.rise) begin
							n.count = r.load_init;
						end else if (s_evt.rise) begin
							n.count = cnt_down;
							if (fire) begin
								n.tc    = 1'h1;
								n.out   = alt_out ? 1'h1 : ~r.out;
								n.count = r.load_width;
								n.st    = GCF_S_WIDTH;
							end
						end
					end
					default: begin
						if (buffered) begin
							n.count = cnt_adv;
							if (end_hit) begin
								sv.latch = 1'h1;
								if (start_hit) begin
									n.count = r.load_init;
								end else begin
									n.st = GCF_S_WAIT;
								end
							end
						end
					end
				endcase
			end
			GCF_S_WIDTH: begin
				if (trig == GCF_T_EVERY && g_evt.rise) begin
					n.count = r.load_init;
					n.out   = GCF_OUT_IDLE;
					n.st    = GCF_S_RUN;
				end else if (s_evt.rise) begin
					n.count = cnt_down;
					if (fire) begin
						n.tc  = 1'h1;
						n.out = alt_out ? 1'h1 : ~r.out;
						n.st  = (trig == GCF_T_EVERY) ? GCF_S_WAIT : GCF_S_DONE;
					end
				end
			end
			GCF_S_DONE: begin
				n.st = GCF_S_DONE;
			end
			default: begin
				n.st = GCF_S_IDLE;
			end
		endcase
		if (count_wr) begin
			n.count = load_value;
		end
		if (disarm) begin
			n.st = GCF_S_IDLE;
		end
	end

	always_ff @(posedge ref_clk) begin
		if (!rst_b) begin
			r <= GCF_TOP_RST;
		end else begin
			r <= n;
		end
	end

	////////////////////////////////////////////////////////////////////////
	// Checks
	property p_unarmed_hold;
		@(posedge ref_clk) disable iff (!rst_b)
		r.st == GCF_S_IDLE && !arm && !count_wr |=> count_value == $past(count_value);
	endproperty
	a_unarmed_hold: assert property (p_unarmed_hold)
		else $error("count moved before arming");

	property p_simple_up;
		@(posedge ref_clk) disable iff (!rst_b)
		r.st == GCF_S_RUN && md == GCF_M_SIMPLE && s_evt.rise && up_down && !count_wr
			&& !disarm |=> count_value == $past(count_value) + GCF_CNT_ONE;
	endproperty
	a_simple_up: assert property (p_simple_up)
		else $error("simple count did not increment");

	property p_gated_hold;
		@(posedge ref_clk) disable iff (!rst_b)
		r.st == GCF_S_RUN && md == GCF_M_GATED && !g_evt.lvl && !count_wr
			|=> count_value == $past(count_value);
	endproperty
	a_gated_hold: assert property (p_gated_hold)
		else $error("gated count moved with gate inactive");

	property p_noncum_reload;
		@(posedge ref_clk) disable iff (!rst_b)
		r.st == GCF_S_RUN && md == GCF_M_NONCUM && g_evt.rise && !count_wr
			|=> count_value == $past(r.load_init) && save_irq;
	endproperty
	a_noncum_reload: assert property (p_noncum_reload)
		else $error("interval boundary did not reload and interrupt");

	property p_cum_save;
		@(posedge ref_clk) disable iff (!rst_b)
		r.st == GCF_S_RUN && md == GCF_M_CUM && g_evt.rise && !s_evt.rise
			|=> save_value == $past(count_value) && save_irq;
	endproperty
	a_cum_save: assert property (p_cum_save)
		else $error("cumulative save missing");

	property p_pos_down;
		@(posedge ref_clk) disable iff (!rst_b)
		r.st == GCF_S_RUN && md == GCF_M_POSITION && s_evt.rise && !up_down && !count_wr
			&& !disarm |=> count_value == $past(count_value) - GCF_CNT_ONE;
	endproperty
	a_pos_down: assert property (p_pos_down)
		else $error("negative movement did not decrement");

	property p_period_done;
		@(posedge ref_clk) disable iff (!rst_b)
		r.st == GCF_S_RUN && md == GCF_M_PERIOD && end_hit && !disarm
			|=> r.st == GCF_S_DONE && save_value == $past(cnt_adv) && save_irq;
	endproperty
	a_period_done: assert property (p_period_done)
		else $error("single period did not latch and stop");

	property p_alt_pulse;
		@(posedge ref_clk) disable iff (!rst_b)
		alt_out && ctr_out && !fire |=> !ctr_out;
	endproperty
	a_alt_pulse: assert property (p_alt_pulse)
		else $error("alternate output wider than one cycle");

	property p_buf_latch;
		@(posedge ref_clk) disable iff (!rst_b)
		r.st == GCF_S_RUN && buffered && end_hit ##1 !save_ack |=> save_irq;
	endproperty
	a_buf_latch: assert property (p_buf_latch)
		else $error("buffered measurement lost its interrupt");

endmodule

// ===== gcf_edge.sv
module gcf_edge
	import gcf_pkg::*;
(
	// Clock and reset
	input  wire logic ref_clk,
	input  wire logic rst_b,
	// Timing input
	input  wire logic level,
	input  wire logic invert,
	// Transitions
	gcf_evt_if.drv    evt
);

	gcf_edge_state_t r;
	gcf_edge_state_t n;
	logic            cur;

	assign cur      = level ^ invert;
	assign evt.lvl  = cur;
	assign evt.rise = cur & ~r.prev;
	assign evt.fall = ~cur & r.prev;

	always_comb begin
		n      = r;
		n.prev = cur;
	end

	always_ff @(posedge ref_clk) begin
		if (!rst_b) begin
			r <= GCF_EDGE_RST;
		end else begin
			r <= n;
		end
	end

endmodule

// ===== gcf_ext_model.sv
module gcf_ext_model (
	// Clock
	input  wire logic ref_clk,
	// Timing signals
	output logic      src,
	output logic      gate
);
	timeunit 1ns;
	timeprecision 1ps;

	initial begin
		src = 1'h0;
		gate = 1'h0;
	end

	////////////////////////////////////////////////////////////////////////
	// Half a source period: level set, then one clock edge samples it
	task automatic src_half(input logic v);
		src = v;
		@(posedge ref_clk) #1;
	endtask

	// Each event is a whole low-high-low source period
	task automatic src_pulses(input int n);
		repeat (n) begin
			src_half(1'h1);
			src_half(1'h0);
		end
	endtask

	// Gate level held two cycles: edge seen, then save flag settles
	task automatic set_gate(input logic v);
		gate = v;
		repeat (2) @(posedge ref_clk) #1;
	endtask
endmodule

// ===== gcf_if.sv
// Transitions of one timing input
interface gcf_evt_if;
	logic lvl;
	logic rise;
	logic fall;
	modport drv (output lvl, rise, fall);
	modport snk (input lvl, rise, fall);
endinterface

// Hardware save register and its pending event
interface gcf_save_if;
	logic        latch;
	logic [23:0] value;
	logic        ack;
	logic [23:0] held;
	logic        irq;
	modport ctl (output latch, value, ack, input held, irq);
	modport sav (input latch, value, ack, output held, irq);
endinterface

// ===== gcf_pkg.sv
package gcf_pkg;

	////////////////////////////////////////////////////////////////////////
	// Widths and constants
	localparam int          GCF_CW       = 24;
	localparam logic [23:0] GCF_CNT_ZERO = 24'h000000;
	localparam logic [23:0] GCF_CNT_ONE  = 24'h000001;
	localparam logic        GCF_OUT_IDLE = 1'h0;

	////////////////////////////////////////////////////////////////////////
	// Counter functions
	typedef enum logic [3:0] {
		GCF_M_SIMPLE   = 4'h0,
		GCF_M_GATED    = 4'h1,
		GCF_M_NONCUM   = 4'h2,
		GCF_M_CUM      = 4'h3,
		GCF_M_POSITION = 4'h4,
		GCF_M_PERIOD   = 4'h5,
		GCF_M_PWIDTH   = 4'h6,
		GCF_M_BPERIOD  = 4'h7,
		GCF_M_BSEMI    = 4'h8,
		GCF_M_BPWIDTH  = 4'h9,
		GCF_M_PULSE    = 4'hA
	} gcf_mode_t;

	// Gate edge that opens or closes a measurement interval
	typedef enum logic [1:0] {
		GCF_E_ACTIVE   = 2'h0,
		GCF_E_INACTIVE = 2'h1,
		GCF_E_EITHER   = 2'h2
	} gcf_edge_sel_t;

	// Gate trigger of pulse generation
	typedef enum logic [1:0] {
		GCF_T_NONE  = 2'h0,
		GCF_T_FIRST = 2'h1,
		GCF_T_EVERY = 2'h2
	} gcf_trig_t;

	typedef enum logic [2:0] {
		GCF_S_IDLE  = 3'b000,
		GCF_S_WAIT  = 3'b001,
		GCF_S_RUN   = 3'b010,
		GCF_S_WIDTH = 3'b011,
		GCF_S_DONE  = 3'b100
	} gcf_state_t;

	////////////////////////////////////////////////////////////////////////
	// Module state records
	typedef struct packed {
		logic prev;
	} gcf_edge_state_t;

	typedef struct packed {
		logic [23:0] held;
		logic        irq;
	} gcf_save_state_t;

	typedef struct packed {
		gcf_state_t  st;
		logic [23:0] count;
		logic [23:0] load_init;
		logic [23:0] load_width;
		logic        out;
		logic        tc;
	} gcf_top_state_t;

	localparam gcf_edge_state_t GCF_EDGE_RST = '{prev: 1'h0};
	localparam gcf_save_state_t GCF_SAVE_RST = '{held: GCF_CNT_ZERO, irq: 1'h0};
	localparam gcf_top_state_t  GCF_TOP_RST  = '{st: GCF_S_IDLE, count: GCF_CNT_ZERO,
		load_init: GCF_CNT_ZERO, load_width: GCF_CNT_ZERO, out: GCF_OUT_IDLE, tc: 1'h0};

	// Does a gate transition match an edge selection
	function automatic logic gcf_edge_hit(logic [1:0] sel, logic rise, logic fall);
		logic hit;
		case (sel)
			GCF_E_ACTIVE:   hit = rise;
			GCF_E_INACTIVE: hit = fall;
			default:        hit = rise | fall;
		endcase
		return hit;
	endfunction

endpackage

// ===== gcf_save.sv
module gcf_save
	import gcf_pkg::*;
(
	// Clock and reset
	input  wire logic ref_clk,
	input  wire logic rst_b,
	// Save port
	gcf_save_if.sav   sv
);

	gcf_save_state_t r;
	gcf_save_state_t n;

	assign sv.held = r.held;
	assign sv.irq  = r.irq;

	always_comb begin
		n = r;
		if (sv.latch) begin
			n.held = sv.value;
		end
		n.irq = sv.latch | (r.irq & ~sv.ack);
	end

	always_ff @(posedge ref_clk) begin
		if (!rst_b) begin
			r <= GCF_SAVE_RST;
		end else begin
			r <= n;
		end
	end

	////////////////////////////////////////////////////////////////////////
	// Checks
	property p_irq_held;
		@(posedge ref_clk) disable iff (!rst_b)
		sv.irq && !sv.ack |=> sv.irq;
	endproperty
	a_irq_held: assert property (p_irq_held)
		else $error("save event dropped before acknowledge");

	property p_held_stable;
		@(posedge ref_clk) disable iff (!rst_b)
		!sv.latch |=> sv.held == $past(sv.held);
	endproperty
	a_held_stable: assert property (p_held_stable)
		else $error("save register changed without a latch");

endmodule

// ===== test_general_counter_functions.sv
module test_general_counter_functions
	import gcf_pkg::*;
;
	timeunit 1ns;
	timeprecision 1ps;

	logic        ref_clk;
	logic        rst_b;
	logic        src;
	logic        gate;
	logic        up_down;
	logic        ctr_out;
	logic        arm;
	logic        disarm;
	logic [3:0]  mode;
	logic [1:0]  start_sel;
	logic [1:0]  end_sel;
	logic [1:0]  trig_sel;
	logic        gate_invert;
	logic        alt_out;
	logic [23:0] load_value;
	logic        load_init_wr;
	logic        load_width_wr;
	logic        count_wr;
	logic [23:0] count_value;
	logic [23:0] save_value;
	logic        armed;
	logic        terminal_count;
	logic        save_irq;
	logic        save_ack;
	int          err_count = 0;
	int          n_compared = 0;

	gcf_ext_model i_gcf_ext_model (.ref_clk(ref_clk), .src(src), .gate(gate));

	gcf_counter i_gcf_counter (
		.ref_clk(ref_clk), .rst_b(rst_b), .src(src), .gate(gate), .up_down(up_down),
		.ctr_out(ctr_out), .arm(arm), .disarm(disarm), .mode(mode),
		.start_sel(start_sel), .end_sel(end_sel), .trig_sel(trig_sel),
		.gate_invert(gate_invert), .alt_out(alt_out), .load_value(load_value),
		.load_init_wr(load_init_wr), .load_width_wr(load_width_wr),
		.count_wr(count_wr), .count_value(count_value), .save_value(save_value),
		.armed(armed), .terminal_count(terminal_count), .save_irq(save_irq),
		.save_ack(save_ack)
	);

	always #10 ref_clk = ~ref_clk;

	////////////////////////////////////////////////////////////////////////
	task automatic test_done();
		$display("compared %0d mismatches %0d", n_compared, err_count);
		if (err_count == 0 && n_compared > 0) begin
			$display("verification passed");
		end else begin
			$display("verification failed");
		end
		$finish;
	endtask

	task automatic chk24(input string nm, input logic [23:0] e, input logic [23:0] g);
		n_compared++;
		if (g !== e) begin
			err_count++;
			$display("wrong value %s expected %h seen %h", nm, e, g);
		end
	endtask

	task automatic chk1(input string nm, input logic e, input logic g);
		n_compared++;
		if (g !== e) begin
			err_count++;
			$display("wrong value %s expected %b seen %b", nm, e, g);
		end
	endtask

	task automatic step(input int n);
		repeat (n) @(posedge ref_clk) #1;
	endtask

	// Disarm, load initial value and counter, then arm
	task automatic start(input logic [3:0] m, input logic [23:0] v);
		disarm = 1'h1;
		mode = m;
		load_value = v;
		step(1);
		disarm = 1'h0;
		load_init_wr = 1'h1;
		count_wr = 1'h1;
		step(1);
		load_init_wr = 1'h0;
		count_wr = 1'h0;
		arm = 1'h1;
		step(1);
		arm = 1'h0;
	endtask

	task automatic ack();
		save_ack = 1'h1;
		step(1);
		save_ack = 1'h0;
		chk1("save_irq", 1'h0, save_irq);
	endtask

	////////////////////////////////////////////////////////////////////////
	task automatic t_reset();
		chk24("count", 24'h000000, count_value);
		chk24("save", 24'h000000, save_value);
		chk1("armed", 1'h0, armed);
		chk1("ctr_out", 1'h0, ctr_out);
		chk1("save_irq", 1'h0, save_irq);
		chk1("terminal_count", 1'h0, terminal_count);
		i_gcf_ext_model.src_pulses(3);
		chk24("count", 24'h000000, count_value);
	endtask

	task automatic t_simple();
		start(GCF_M_SIMPLE, 24'h000000);
		chk1("armed", 1'h1, armed);
		i_gcf_ext_model.src_pulses(5);
		chk24("count", 24'h000005, count_value);
		up_down = 1'h0;
		i_gcf_ext_model.src_pulses(2);
		chk24("count", 24'h000003, count_value);
		up_down = 1'h1;
	endtask

	task automatic t_gated();
		start(GCF_M_GATED, 24'h000000);
		i_gcf_ext_model.src_pulses(2);
		chk24("count", 24'h000000, count_value);
		i_gcf_ext_model.set_gate(1'h1);
		i_gcf_ext_model.src_pulses(3);
		i_gcf_ext_model.set_gate(1'h0);
		i_gcf_ext_model.src_pulses(2);
		chk24("count", 24'h000003, count_value);
	endtask

	task automatic t_noncum();
		start(GCF_M_NONCUM, 24'h00000A);
		i_gcf_ext_model.src_pulses(3);
		i_gcf_ext_model.set_gate(1'h1);
		chk24("save", 24'h00000D, save_value);
		chk24("count", 24'h00000A, count_value);
		chk1("save_irq", 1'h1, save_irq);
		ack();
		i_gcf_ext_model.src_pulses(2);
		chk24("count", 24'h00000C, count_value);
		chk24("save", 24'h00000D, save_value);
		i_gcf_ext_model.set_gate(1'h0);
	endtask

	task automatic t_cum();
		start(GCF_M_CUM, 24'h000000);
		i_gcf_ext_model.src_pulses(3);
		i_gcf_ext_model.set_gate(1'h1);
		chk24("save", 24'h000003, save_value);
		chk1("save_irq", 1'h1, save_irq);
		ack();
		i_gcf_ext_model.src_pulses(2);
		i_gcf_ext_model.set_gate(1'h0);
		i_gcf_ext_model.set_gate(1'h1);
		chk24("save", 24'h000005, save_value);
		chk24("count", 24'h000005, count_value);
		chk1("save_irq", 1'h1, save_irq);
		ack();
		i_gcf_ext_model.set_gate(1'h0);
	endtask

	task automatic t_pos();
		start(GCF_M_POSITION, 24'h000001);
		up_down = 1'h0;
		i_gcf_ext_model.src_half(1'h1);
		chk24("count", 24'h000000, count_value);
		chk1("terminal_count", 1'h1, terminal_count);
		i_gcf_ext_model.src_half(1'h0);
		chk1("terminal_count", 1'h0, terminal_count);
		i_gcf_ext_model.src_pulses(1);
		chk24("count", 24'hFFFFFF, count_value);
		up_down = 1'h1;
		i_gcf_ext_model.src_pulses(1);
		chk24("count", 24'h000000, count_value);
		start(GCF_M_POSITION, 24'hFFFFFE);
		i_gcf_ext_model.src_pulses(1);
		chk24("count", 24'hFFFFFF, count_value);
	endtask

	task automatic t_period();
		start(GCF_M_PERIOD, 24'h000000);
		i_gcf_ext_model.set_gate(1'h1);
		i_gcf_ext_model.src_pulses(4);
		i_gcf_ext_model.set_gate(1'h0);
		i_gcf_ext_model.set_gate(1'h1);
		chk24("save", 24'h000004, save_value);
		chk1("armed", 1'h0, armed);
		ack();
		i_gcf_ext_model.set_gate(1'h0);
	endtask

	task automatic t_semi();
		start(GCF_M_BSEMI, 24'h000000);
		i_gcf_ext_model.set_gate(1'h1);
		i_gcf_ext_model.src_pulses(3);
		i_gcf_ext_model.set_gate(1'h0);
		chk24("save", 24'h000003, save_value);
		ack();
		i_gcf_ext_model.src_pulses(1);
		i_gcf_ext_model.set_gate(1'h1);
		chk24("save", 24'h000001, save_value);
		chk1("save_irq", 1'h1, save_irq);
		ack();
		i_gcf_ext_model.set_gate(1'h0);
	endtask

	task automatic t_pulse();
		load_value = 24'h000003;
		load_width_wr = 1'h1;
		step(1);
		load_width_wr = 1'h0;
		start(GCF_M_PULSE, 24'h000002);
		i_gcf_ext_model.src_pulses(2);
		chk1("ctr_out", 1'h1, ctr_out);
		i_gcf_ext_model.src_pulses(3);
		chk1("ctr_out", 1'h0, ctr_out);
		chk1("armed", 1'h0, armed);
	endtask

	// Active level is low gate; interval ends on the inactive edge
	task automatic t_pwidth();
		gate_invert = 1'h1;
		end_sel = GCF_E_INACTIVE;
		start(GCF_M_PWIDTH, 24'h000000);
		i_gcf_ext_model.set_gate(1'h1);
		i_gcf_ext_model.src_pulses(2);
		i_gcf_ext_model.set_gate(1'h0);
		i_gcf_ext_model.src_pulses(3);
		chk24("count", 24'h000003, count_value);
		i_gcf_ext_model.set_gate(1'h1);
		chk24("save", 24'h000003, save_value);
		chk1("armed", 1'h0, armed);
		chk1("save_irq", 1'h1, save_irq);
		ack();
		i_gcf_ext_model.set_gate(1'h0);
		gate_invert = 1'h0;
		end_sel = GCF_E_ACTIVE;
	endtask

	task automatic t_bperiod();
		start_sel = GCF_E_EITHER;
		start(GCF_M_BPERIOD, 24'h000000);
		i_gcf_ext_model.set_gate(1'h1);
		i_gcf_ext_model.src_pulses(2);
		i_gcf_ext_model.set_gate(1'h0);
		i_gcf_ext_model.src_pulses(1);
		i_gcf_ext_model.set_gate(1'h1);
		chk24("save", 24'h000003, save_value);
		chk24("count", 24'h000000, count_value);
		chk1("save_irq", 1'h1, save_irq);
		ack();
		i_gcf_ext_model.src_pulses(2);
		i_gcf_ext_model.set_gate(1'h0);
		i_gcf_ext_model.set_gate(1'h1);
		chk24("save", 24'h000002, save_value);
		chk1("save_irq", 1'h1, save_irq);
		ack();
		i_gcf_ext_model.set_gate(1'h0);
		start_sel = GCF_E_ACTIVE;
	endtask

	task automatic t_bpwidth();
		end_sel = GCF_E_INACTIVE;
		start(GCF_M_BPWIDTH, 24'h000000);
		i_gcf_ext_model.set_gate(1'h1);
		i_gcf_ext_model.src_pulses(3);
		i_gcf_ext_model.set_gate(1'h0);
		chk24("save", 24'h000003, save_value);
		chk1("save_irq", 1'h1, save_irq);
		ack();
		i_gcf_ext_model.src_pulses(1);
		i_gcf_ext_model.set_gate(1'h1);
		i_gcf_ext_model.src_pulses(2);
		i_gcf_ext_model.set_gate(1'h0);
		chk24("save", 24'h000002, save_value);
		chk1("armed", 1'h1, armed);
		ack();
		end_sel = GCF_E_ACTIVE;
	endtask

	// First gate edge triggers; alternate output gives two short pulses
	task automatic t_trig();
		alt_out = 1'h1;
		trig_sel = GCF_T_FIRST;
		load_value = 24'h000001;
		load_width_wr = 1'h1;
		step(1);
		load_width_wr = 1'h0;
		start(GCF_M_PULSE, 24'h000002);
		i_gcf_ext_model.src_pulses(2);
		chk24("count", 24'h000002, count_value);
		i_gcf_ext_model.set_gate(1'h1);
		i_gcf_ext_model.src_pulses(1);
		i_gcf_ext_model.src_half(1'h1);
		chk1("ctr_out", 1'h1, ctr_out);
		chk1("terminal_count", 1'h1, terminal_count);
		i_gcf_ext_model.src_half(1'h0);
		chk1("ctr_out", 1'h0, ctr_out);
		i_gcf_ext_model.src_half(1'h1);
		chk1("ctr_out", 1'h1, ctr_out);
		i_gcf_ext_model.src_half(1'h0);
		chk1("ctr_out", 1'h0, ctr_out);
		chk1("armed", 1'h0, armed);
		i_gcf_ext_model.set_gate(1'h0);
		alt_out = 1'h0;
	endtask

	// Every active (rising) gate edge retriggers and restarts the delay
	task automatic t_retrig();
		trig_sel = GCF_T_EVERY;
		load_value = 24'h000002;
		load_width_wr = 1'h1;
		step(1);
		load_width_wr = 1'h0;
		start(GCF_M_PULSE, 24'h000003);
		i_gcf_ext_model.set_gate(1'h1);
		i_gcf_ext_model.src_pulses(1);
		i_gcf_ext_model.set_gate(1'h0);
		i_gcf_ext_model.set_gate(1'h1);
		i_gcf_ext_model.src_pulses(2);
		chk24("count", 24'h000001, count_value);
		chk1("ctr_out", 1'h0, ctr_out);
		i_gcf_ext_model.src_pulses(1);
		chk1("ctr_out", 1'h1, ctr_out);
		i_gcf_ext_model.src_pulses(2);
		chk1("ctr_out", 1'h0, ctr_out);
		chk1("armed", 1'h1, armed);
		i_gcf_ext_model.set_gate(1'h0);
		trig_sel = GCF_T_NONE;
	endtask

	////////////////////////////////////////////////////////////////////////
	initial begin
		ref_clk = 1'h0;
		rst_b = 1'h0;
		up_down = 1'h1;
		arm = 1'h0;
		disarm = 1'h0;
		mode = GCF_M_SIMPLE;
		start_sel = GCF_E_ACTIVE;
		end_sel = GCF_E_ACTIVE;
		trig_sel = GCF_T_NONE;
		gate_invert = 1'h0;
		alt_out = 1'h0;
		load_value = 24'h000000;
		load_init_wr = 1'h0;
		load_width_wr = 1'h0;
		count_wr = 1'h0;
		save_ack = 1'h0;
		repeat (6) @(posedge ref_clk);
		#1;
		rst_b = 1'h1;
		step(1);
		t_reset();
		t_simple();
		t_gated();
		t_noncum();
		t_cum();
		t_pos();
		t_period();
		t_semi();
		t_pulse();
		t_pwidth();
		t_bperiod();
		t_bpwidth();
		t_trig();
		t_retrig();
		test_done();
	end

	initial begin
		repeat (20000) @(posedge ref_clk);
		err_count++;
		test_done();
	end
endmodule
